// ---- common/mchr_pkg.sv ----
// Shared constants and carrier types for the card host control register bank.
package mchr_pkg;

    // ----------
    // Register byte offsets
    // ----------
    localparam logic [7:0] MCHR_OFS_CONTROL = 8'h00;
    localparam logic [7:0] MCHR_OFS_MODE = 8'h04;
    localparam logic [7:0] MCHR_OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] MCHR_OFS_SLOT = 8'h0C;
    localparam logic [7:0] MCHR_OFS_ARGUMENT = 8'h10;
    localparam logic [7:0] MCHR_OFS_COMMAND = 8'h14;
    localparam logic [7:0] MCHR_OFS_STATUS = 8'h40;

    // ----------
    // Field positions
    // ----------
    localparam int MCHR_CTL_IFACE_ON = 0;
    localparam int MCHR_CTL_IFACE_OFF = 1;
    localparam int MCHR_CTL_PS_ON = 2;
    localparam int MCHR_CTL_PS_OFF = 3;
    localparam int MCHR_MODE_DMA = 15;
    localparam int MCHR_MODE_PAD = 14;
    localparam int MCHR_SLOT_SEL = 0;
    localparam int MCHR_SLOT_BUS = 7;
    localparam int MCHR_ST_CMD_READY = 0;
    localparam int MCHR_ST_INIT = 1;
    localparam int MCHR_ST_IFACE = 2;
    localparam int MCHR_ST_PS = 3;
    localparam int MCHR_ST_RESP_TO = 20;
    localparam int MCHR_ST_DATA_TO = 22;
    localparam int MCHR_ST_OVERRUN = 30;
    localparam int MCHR_ST_UNDERRUN = 31;

    // ----------
    // Reset values, codes and counts
    // ----------
    localparam logic [31:0] MCHR_RESET_VALUE = 32'h0000_0000;
    localparam logic [7:0] MCHR_PAD_LOW = 8'h00;
    localparam logic [7:0] MCHR_PAD_HIGH = 8'hFF;
    localparam logic [6:0] MCHR_INIT_CYCLES = 7'h4A;
    localparam logic [6:0] MCHR_LAT_SHORT = 7'h05;
    localparam logic [6:0] MCHR_LAT_LONG = 7'h40;
    localparam logic [2:0] MCHR_SPC_NORMAL = 3'h0;
    localparam logic [2:0] MCHR_SPC_INIT = 3'h1;
    localparam logic [2:0] MCHR_SPC_SYNC = 3'h2;
    localparam logic [1:0] MCHR_RSP_NONE = 2'h0;
    localparam logic [1:0] MCHR_TRC_START = 2'h1;

    // Command word, as command register bits 20:0.
    typedef struct packed {
        logic [1:0] transfer_kind;
        logic transfer_direction;
        logic [1:0] transfer_command;
        logic [2:0] spare;
        logic response_latency_limit;
        logic open_drain_select;
        logic [2:0] special_command;
        logic [1:0] response_kind;
        logic [5:0] command_index;
    } mchr_cmd_type;

    // Mode and slot register fields that leave the block.
    typedef struct packed {
        logic dma_oriented_mode;
        logic [7:0] pad_byte;
        logic [11:0] block_length;
        logic slot_select;
        logic bus_width_select;
    } mchr_cfg_type;

endpackage

// ---- hdl/mchr_regs.sv ----
// Register bank, card clock divider and command sequencer of the card host.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
// How it works
// - Iface on bit enables unless iface off is also set.
// - Iface off bit disables; zero does nothing.
// - Power save on bit enters unless off is also set.
// - Power save off bit leaves saving; zero does nothing.
// - Card clock is master clock over 2*(divider+1).
// - Power save divides the card clock by 2^n more.
// - Pad byte is 0x00 or 0xFF by pad select.
// - DMA mode silences underrun and overrun flags.
// - Data timeout after cycles times multiplier clocks.
// - Codes 0-7 give 1,16,128,256,1024,4096,65536,1048576.
// - Slot select picks A or B; width picks 1 or 4 bits.
// - Argument register is 32-bit read/write.
// - Command writes drop while busy.
// - Response kind: none, 48-bit, 136-bit, reserved.
// - Code one sends a 74 card clock init sequence.
// - Code two waits for the data block end.
// - Code zero normal, three reserved, four, five interrupt.
// - Open-drain bit picks the command driver style.
// - Latency bit allows 5 or 64 card clocks.
// - Transfer command: none, start, stop, reserved.
// - Direction write/read; kind single, multiple, stream.
// - Command write drops ready and launches at once, except code one and a held code two.
module mchr_regs
    import mchr_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Avalon-MM slave.
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Card engine events, same clock.
    input wire logic cmd_sent_i,
    input wire logic resp_start_i,
    input wire logic resp_done_i,
    input wire logic data_active_i,
    input wire logic block_end_i,
    input wire logic underrun_i,
    input wire logic overrun_i,
    // Card engine controls.
    output logic card_clock_o,
    output logic iface_enabled_o,
    output logic power_save_o,
    output mchr_cfg_type cfg_o,
    output logic [31:0] cmd_argument_o,
    output mchr_cmd_type cmd_word_o,
    output logic cmd_launch_o,
    output logic init_seq_o,
    output logic command_ready_flag_o,
    output logic resp_timeout_o,
    output logic data_timeout_o,
    output logic underrun_flag_o,
    output logic overrun_flag_o
);
    // ----------
    // Helper functions
    // ----------
    // Multiplier from its code.
    function automatic logic [20:0] timeout_mult(input logic [2:0] code);
        logic [20:0] m;
        m = 21'h00_0001;
        unique case (code)
            3'h0: m = 21'h00_0001;
            3'h1: m = 21'h00_0010;
            3'h2: m = 21'h00_0080;
            3'h3: m = 21'h00_0100;
            3'h4: m = 21'h00_0400;
            3'h5: m = 21'h00_1000;
            3'h6: m = 21'h01_0000;
            3'h7: m = 21'h10_0000;
        endcase
        return m;
    endfunction
    // Byte-lane merge.
    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction
    // ----------
    // Storage
    // ----------
    typedef enum logic [2:0] {
        CMD_IDLE = 3'b000,
        CMD_HOLD = 3'b001,
        CMD_INIT = 3'b010,
        CMD_SEND = 3'b011,
        CMD_LATENCY = 3'b100,
        CMD_RESP = 3'b101
    } mchr_state_type;
    mchr_state_type state;
    logic [31:0] mode_reg;
    logic [31:0] timeout_reg;
    logic [31:0] slot_reg;
    logic [15:0] div_count;
    logic card_tick;
    logic [6:0] tick_count;
    logic [24:0] dto_count;
    logic [31:0] next_readdata;
    logic bus_take;
    logic wr_take;
    logic cmd_accept;
    logic [31:0] wr_value;
    logic [15:0] div_limit;
    logic [24:0] dto_limit;
    logic [6:0] lat_limit;
    mchr_cmd_type new_cmd;
    // ----------
    // Avalon slave handshake
    // ----------
    // Taken where waitrequest is low.
    assign bus_take = (read_i || write_i) && !waitrequest_o;
    assign wr_take = write_i && !waitrequest_o;
    assign wr_value = writedata_i;
    assign new_cmd = mchr_cmd_type'(wr_value[20:0]);
    // Busy commands are dropped silently so a running one cannot be altered.
    assign cmd_accept = wr_take && (address_i == MCHR_OFS_COMMAND) && command_ready_flag_o;
    // One wait cycle per access keeps the read mux out of the bus path.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            waitrequest_o <= bus_take || !(read_i || write_i);
        end
    end
    // Write-only and unmapped words read zero.
    always_comb begin
        next_readdata = MCHR_RESET_VALUE;
        unique case (address_i)
            MCHR_OFS_MODE: next_readdata = mode_reg;
            MCHR_OFS_TIMEOUT: next_readdata = timeout_reg;
            MCHR_OFS_SLOT: next_readdata = slot_reg;
            MCHR_OFS_ARGUMENT: next_readdata = cmd_argument_o;
            MCHR_OFS_STATUS: begin
                next_readdata[MCHR_ST_CMD_READY] = command_ready_flag_o;
                next_readdata[MCHR_ST_INIT] = init_seq_o;
                next_readdata[MCHR_ST_IFACE] = iface_enabled_o;
                next_readdata[MCHR_ST_PS] = power_save_o;
                next_readdata[MCHR_ST_RESP_TO] = resp_timeout_o;
                next_readdata[MCHR_ST_DATA_TO] = data_timeout_o;
                next_readdata[MCHR_ST_OVERRUN] = overrun_flag_o;
                next_readdata[MCHR_ST_UNDERRUN] = underrun_flag_o;
            end
            default: next_readdata = MCHR_RESET_VALUE;
        endcase
    end
    // Loaded as waitrequest drops, so it stands when taken.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            readdata_o <= MCHR_RESET_VALUE;
        end else if (ce_i && read_i && waitrequest_o) begin
            readdata_o <= next_readdata;
        end
    end
    // ----------
    // Control register: enable and power-save latches
    // ----------
    // Disable bits win over enable bits in the same write.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            iface_enabled_o <= 1'b0;
            power_save_o <= 1'b0;
        end else if (ce_i && wr_take && address_i == MCHR_OFS_CONTROL && byteenable_i[0]) begin
            if (wr_value[MCHR_CTL_IFACE_OFF]) begin
                iface_enabled_o <= 1'b0;
            end else if (wr_value[MCHR_CTL_IFACE_ON]) begin
                iface_enabled_o <= 1'b1;
            end
            if (wr_value[MCHR_CTL_PS_OFF]) begin
                power_save_o <= 1'b0;
            end else if (wr_value[MCHR_CTL_PS_ON]) begin
                power_save_o <= 1'b1;
            end
        end
    end
    // ----------
    // Read/write configuration registers
    // ----------
    // Masks keep reserved bits zero.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg <= MCHR_RESET_VALUE;
            timeout_reg <= MCHR_RESET_VALUE;
            slot_reg <= MCHR_RESET_VALUE;
            cmd_argument_o <= MCHR_RESET_VALUE;
        end else if (ce_i && wr_take) begin
            unique case (address_i)
                MCHR_OFS_MODE: mode_reg <= be_merge(mode_reg, wr_value, byteenable_i) & 32'h3FFC_C7FF;
                MCHR_OFS_TIMEOUT: timeout_reg <= be_merge(timeout_reg, wr_value, byteenable_i) & 32'h0000_007F;
                MCHR_OFS_SLOT: slot_reg <= be_merge(slot_reg, wr_value, byteenable_i) & 32'h0000_0081;
                MCHR_OFS_ARGUMENT: cmd_argument_o <= be_merge(cmd_argument_o, wr_value, byteenable_i);
                default: mode_reg <= mode_reg;
            endcase
        end
    end
    // Outputs lag the registers by one cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_o <= '0;
        end else if (ce_i) begin
            cfg_o.dma_oriented_mode <= mode_reg[MCHR_MODE_DMA];
            cfg_o.pad_byte <= mode_reg[MCHR_MODE_PAD] ? MCHR_PAD_HIGH : MCHR_PAD_LOW;
            cfg_o.block_length <= mode_reg[29:18];
            cfg_o.slot_select <= slot_reg[MCHR_SLOT_SEL];
            cfg_o.bus_width_select <= slot_reg[MCHR_SLOT_BUS];
        end
    end
    // ----------
    // Card clock divider
    // ----------
    // Half period, stretched by 2^n in power save.
    assign div_limit = power_save_o
        ? 16'((17'(mode_reg[7:0]) + 17'h0_0001) << mode_reg[10:8]) - 16'h0001
        : 16'(mode_reg[7:0]);
    // The clock stops low while the interface is off.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_count <= 16'h0000;
            card_clock_o <= 1'b0;
            card_tick <= 1'b0;
        end else if (ce_i) begin
            card_tick <= 1'b0;
            if (!iface_enabled_o) begin
                div_count <= 16'h0000;
                card_clock_o <= 1'b0;
            end else if (div_count >= div_limit) begin
                div_count <= 16'h0000;
                card_clock_o <= !card_clock_o;
                card_tick <= !card_clock_o;
            end else begin
                div_count <= div_count + 16'h0001;
            end
        end
    end
    // ----------
    // Command sequencer
    // ----------
    // Latency limit in card clocks.
    assign lat_limit = cmd_word_o.response_latency_limit ? MCHR_LAT_LONG : MCHR_LAT_SHORT;
    // Codes three, four and five pass to the engine as plain launches.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= CMD_IDLE;
            cmd_word_o <= '0;
            cmd_launch_o <= 1'b0;
            init_seq_o <= 1'b0;
            command_ready_flag_o <= 1'b1;
            tick_count <= 7'h00;
        end else if (ce_i) begin
            cmd_launch_o <= 1'b0;
            unique case (state)
                CMD_IDLE: begin
                    if (cmd_accept) begin
                        cmd_word_o <= mchr_cmd_type'(new_cmd & 21'h1F_1FFF);
                        command_ready_flag_o <= 1'b0;
                        tick_count <= 7'h00;
                        if (new_cmd.special_command == MCHR_SPC_INIT) begin
                            state <= CMD_INIT;
                            init_seq_o <= 1'b1;
                        end else if (new_cmd.special_command == MCHR_SPC_SYNC && data_active_i) begin
                            state <= CMD_HOLD;
                        end else begin
                            state <= CMD_SEND;
                            cmd_launch_o <= 1'b1;
                        end
                    end
                end
                CMD_HOLD: begin
                    if (block_end_i || !data_active_i) begin
                        state <= CMD_SEND;
                        cmd_launch_o <= 1'b1;
                    end
                end
                CMD_INIT: begin
                    if (card_tick) begin
                        if (tick_count == MCHR_INIT_CYCLES - 7'h01) begin
                            state <= CMD_IDLE;
                            init_seq_o <= 1'b0;
                            command_ready_flag_o <= 1'b1;
                        end else begin
                            tick_count <= tick_count + 7'h01;
                        end
                    end
                end
                CMD_SEND: begin
                    if (cmd_sent_i) begin
                        tick_count <= 7'h00;
                        if (cmd_word_o.response_kind == MCHR_RSP_NONE) begin
                            state <= CMD_IDLE;
                            command_ready_flag_o <= 1'b1;
                        end else begin
                            state <= CMD_LATENCY;
                        end
                    end
                end
                CMD_LATENCY: begin
                    if (resp_start_i) begin
                        state <= CMD_RESP;
                    end else if (card_tick) begin
                        if (tick_count == lat_limit - 7'h01) begin
                            state <= CMD_IDLE;
                            command_ready_flag_o <= 1'b1;
                        end else begin
                            tick_count <= tick_count + 7'h01;
                        end
                    end
                end
                CMD_RESP: begin
                    if (resp_done_i) begin
                        state <= CMD_IDLE;
                        command_ready_flag_o <= 1'b1;
                    end
                end
                default: begin
                    state <= CMD_IDLE;
                    command_ready_flag_o <= 1'b1;
                end
            endcase
        end
    end
    // Set on expiry, cleared by the next accepted command.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resp_timeout_o <= 1'b0;
        end else if (ce_i) begin
            if (state == CMD_LATENCY && !resp_start_i && card_tick && tick_count == lat_limit - 7'h01) begin
                resp_timeout_o <= 1'b1;
            end else if (cmd_accept) begin
                resp_timeout_o <= 1'b0;
            end
        end
    end
    // ----------
    // Data timeout counter
    // ----------
    // Limit is at most 15 x 2^20, so 25 bits hold the product exactly.
    assign dto_limit = 25'(timeout_reg[3:0]) * 25'(timeout_mult(timeout_reg[6:4]));
    // Counts while a transfer waits for a block.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dto_count <= 25'h000_0000;
            data_timeout_o <= 1'b0;
        end else if (ce_i) begin
            if (!data_active_i || block_end_i) begin
                dto_count <= 25'h000_0000;
            end else if (dto_count < dto_limit) begin
                dto_count <= dto_count + 25'h000_0001;
            end
            if (data_active_i && !block_end_i && dto_count >= dto_limit) begin
                data_timeout_o <= 1'b1;
            end else if (cmd_accept) begin
                data_timeout_o <= 1'b0;
            end
        end
    end
    // ----------
    // Underrun and overrun flags
    // ----------
    // Not recorded in DMA mode; a new start clears them.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            underrun_flag_o <= 1'b0;
            overrun_flag_o <= 1'b0;
        end else if (ce_i) begin
            if (underrun_i && !mode_reg[MCHR_MODE_DMA]) begin
                underrun_flag_o <= 1'b1;
            end else if (cmd_accept && new_cmd.transfer_command == MCHR_TRC_START) begin
                underrun_flag_o <= 1'b0;
            end
            if (overrun_i && !mode_reg[MCHR_MODE_DMA]) begin
                overrun_flag_o <= 1'b1;
            end else if (cmd_accept && new_cmd.transfer_command == MCHR_TRC_START) begin
                overrun_flag_o <= 1'b0;
            end
        end
    end
endmodule

// ---- tb/mchr_card_model.sv ----
// Card-side engine model that answers command launches.
`timescale 1ns/100ps
module mchr_card_model
    import mchr_pkg::*;
(
    // Clock, reset and bench controls.
    input wire logic clk_i, resetn_i, launch_i, mute_i, data_on_i,
    input wire mchr_cmd_type word_i,
    input wire logic [3:0] delay_i,
    // Engine events.
    output logic sent_o, start_o, done_o, active_o, block_o
);
    logic [1:0] phase;
    logic [3:0] cnt;
    logic want, last_on;
    // A muted card never answers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= 2'h0; cnt <= 4'h0; want <= 1'b0; sent_o <= 1'b0; start_o <= 1'b0; done_o <= 1'b0;
        end else begin
            sent_o <= 1'b0; start_o <= 1'b0; done_o <= start_o;
            if (launch_i) begin
                phase <= 2'h1; cnt <= delay_i; want <= word_i.response_kind != MCHR_RSP_NONE;
            end else if (phase != 2'h0 && cnt != 4'h0) cnt <= cnt - 4'h1;
            else if (phase == 2'h1) begin
                sent_o <= 1'b1; cnt <= delay_i; phase <= (want && !mute_i) ? 2'h2 : 2'h0;
            end else if (phase == 2'h2) begin
                start_o <= 1'b1; phase <= 2'h0;
            end
        end
    end
    // A block ends when the bench stops the transfer.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) last_on <= 1'b0; else last_on <= data_on_i;
    end
    assign active_o = data_on_i;
    assign block_o = last_on & !data_on_i;
endmodule

// ---- tb/mchr_regs_bench.sv ----
// Self-checking bench for the card host register bank.
`timescale 1ns/100ps
module mchr_regs_bench;
    import mchr_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, read_i = 1'b0, write_i = 1'b0, mute = 1'b0, data_on = 1'b0;
    logic [7:0] address_i = 8'h00, a;
    logic [31:0] writedata_i = 32'h0, readdata_o, cmd_argument_o, d, q;
    logic [3:0] byteenable_i = 4'hF;
    logic waitrequest_o, cmd_sent_i, resp_start_i, resp_done_i, data_active_i, block_end_i, card_clock_o, en, ps;
    logic underrun_i = 1'b0, overrun_i = 1'b0, iface_enabled_o, power_save_o, cmd_launch_o, init_seq_o;
    logic command_ready_flag_o, resp_timeout_o, data_timeout_o, underrun_flag_o, overrun_flag_o;
    mchr_cfg_type cfg_o;
    mchr_cmd_type cmd_word_o;
    int bad_count = 0, check_count = 0, launches = 0, n;
    always #12.5 clk_i = ~clk_i;
    // Counts launches to expose dropped writes.
    always @(posedge clk_i) if (cmd_launch_o === 1'b1) launches <= launches + 1;
    mchr_regs u_dut (.*);
    mchr_card_model u_card (.clk_i(clk_i), .resetn_i(resetn_i), .launch_i(cmd_launch_o), .mute_i(mute),
        .data_on_i(data_on), .word_i(cmd_word_o), .delay_i(4'h6), .sent_o(cmd_sent_i), .start_o(resp_start_i),
        .done_o(resp_done_i), .active_o(data_active_i), .block_o(block_end_i));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access, held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        int k = 0;
        address_i <= ad; writedata_i <= wd; write_i <= wr; read_i <= !wr;
        do begin @(posedge clk_i); k++; end while (waitrequest_o !== 1'b0 && k < 50);
        rd = readdata_o;
        bad_count += int'(k >= 50);
        write_i <= 1'b0; read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_ready();
        repeat (2) @(posedge clk_i);
        n = 0;
        while (command_ready_flag_o !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
        check("ready back", 32'(n < 2000), 32'h1);
    endtask
    // Cycles of one full card clock half.
    task automatic half(output int m);
        logic c;
        for (int j = 0; j < 2; j++) begin
            m = 0; c = card_clock_o;
            while (card_clock_o === c && m < 200) begin @(posedge clk_i); m++; end
        end
    endtask
    function automatic logic [31:0] rd_mask(input logic [7:0] ad);
        case (ad)
            MCHR_OFS_MODE: return 32'h3FFC_C7FF;
            MCHR_OFS_TIMEOUT: return 32'h0000_007F;
            MCHR_OFS_SLOT: return 32'h0000_0081;
            MCHR_OFS_ARGUMENT: return 32'hFFFF_FFFF;
            default: return 32'h0000_0000;
        endcase
    endfunction
    function automatic int limit(input logic [6:0] t);
        int m[8] = '{1, 16, 128, 256, 1024, 4096, 65536, 1048576};
        return int'(t[3:0]) * m[t[6:4]];
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard.
    initial begin
        #1000000;
        bad_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(13));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        bus(0, MCHR_OFS_MODE, 32'h0, q);
        check("mode reset", q, MCHR_RESET_VALUE);
        for (int i = 0; i < 15; i++) begin
            a = (i % 5 == 4) ? 8'h18 : 8'(4 + 4 * (i % 5));
            d = $urandom();
            d[17:16] = 2'h0;
            bus(1, a, d, q);
            bus(0, a, 32'h0, q);
            check("readback", q, d & rd_mask(a));
            if (a == MCHR_OFS_MODE) check("pad", cfg_o.pad_byte, d[14] ? MCHR_PAD_HIGH : MCHR_PAD_LOW);
            if (a == MCHR_OFS_SLOT) check("slot", {cfg_o.slot_select, cfg_o.bus_width_select}, {d[0], d[7]});
        end
        en = 1'b0; ps = 1'b0;
        for (int i = 0; i < 12; i++) begin
            d = i ? 32'($urandom_range(15)) : 32'hF;
            bus(1, MCHR_OFS_CONTROL, d, q);
            en = !d[1] && (d[0] || en);
            ps = !d[3] && (d[2] || ps);
            check("iface", iface_enabled_o, en);
            check("psave", power_save_o, ps);
        end
        bus(1, MCHR_OFS_CONTROL, 32'h9, q);
        bus(1, MCHR_OFS_MODE, 32'h0000_0102, q);
        half(n);
        check("half period", n, 3);
        bus(1, MCHR_OFS_CONTROL, 32'h4, q);
        half(n);
        check("saving half", n, 6);
        bus(1, MCHR_OFS_CONTROL, 32'h8, q);
        bus(1, MCHR_OFS_ARGUMENT, 32'hA5C3_0F96, q);
        n = launches;
        bus(1, MCHR_OFS_COMMAND, 32'h0009_5802, q);
        bus(1, MCHR_OFS_COMMAND, 32'h0000_0005, q);
        d = n + 1;
        wait_ready();
        check("launches", launches, d);
        check("word", cmd_word_o, 32'h0009_1802);
        check("argument", cmd_argument_o, 32'hA5C3_0F96);
        for (int i = 0; i < 4; i++) begin
            mute <= i[1];
            bus(1, MCHR_OFS_COMMAND, i[0] ? 32'h1081 : 32'h0041, q);
            wait_ready();
            check("resp timeout", resp_timeout_o, i[1]);
        end
        mute <= 1'b0;
        bus(1, MCHR_OFS_COMMAND, 32'h0000_0100, q);
        n = 0;
        while (init_seq_o === 1'b1 && n < 999) begin @(posedge clk_i); n++; end
        check("init length", 32'(n > 437 && n < 451), 32'h1);
        wait_ready();
        for (int i = 0; i < 4; i++) begin
            d = {25'h0, 3'(i), 4'h2};
            bus(1, MCHR_OFS_TIMEOUT, d, q);
            bus(1, MCHR_OFS_COMMAND, 32'h0, q);
            wait_ready();
            data_on <= 1'b1;
            n = 0;
            while (data_timeout_o !== 1'b1 && n < 999) begin @(posedge clk_i); n++; end
            data_on <= 1'b0;
            check("data timeout", 32'(n >= limit(d[6:0]) - 1 && n <= limit(d[6:0]) + 4), 32'h1);
        end
        data_on <= 1'b1;
        n = launches;
        bus(1, MCHR_OFS_COMMAND, 32'h0000_0200, q);
        check("held", launches, n);
        data_on <= 1'b0;
        wait_ready();
        check("sync sent", launches, n + 1);
        underrun_i <= 1'b1; overrun_i <= 1'b1;
        @(posedge clk_i);
        underrun_i <= 1'b0; overrun_i <= 1'b0;
        @(posedge clk_i);
        check("flags", {underrun_flag_o, overrun_flag_o}, 2'h3);
        bus(1, MCHR_OFS_COMMAND, 32'h0001_0000, q);
        wait_ready();
        check("flags clear", {underrun_flag_o, overrun_flag_o}, 2'h0);
        give_verdict();
    end
endmodule

// ---- tb/mchr_regs_monitor.sv ----
// Port-level assertions for the card host register bank.
`timescale 1ns/100ps
module mchr_regs_monitor
    import mchr_pkg::*;
(
    // Bus side.
    input wire logic clk_i, resetn_i, write_i, waitrequest_o, data_active_i,
    input wire logic [7:0] address_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    // Engine side.
    input wire logic iface_enabled_o, power_save_o, card_clock_o, cmd_launch_o, command_ready_flag_o, data_timeout_o,
    input wire mchr_cfg_type cfg_o,
    input wire mchr_cmd_type cmd_word_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Accepted control write.
    sequence ctl_wr;
        write_i && !waitrequest_o && address_i == MCHR_OFS_CONTROL && byteenable_i[0];
    endsequence
    chk_off_wins: assert property (ctl_wr ##0 writedata_i[1] |=> !iface_enabled_o) else $error("iface on");
    chk_on_alone: assert property (ctl_wr ##0 writedata_i[1:0] == 2'h1 |=> iface_enabled_o) else $error("iface off");
    chk_ps_off: assert property (ctl_wr ##0 writedata_i[3] |=> !power_save_o) else $error("saving on");
    chk_ps_on: assert property (ctl_wr ##0 writedata_i[3:2] == 2'h1 |=> power_save_o) else $error("saving off");
    chk_launch_busy: assert property (cmd_launch_o |-> !command_ready_flag_o) else $error("ready at launch");
    chk_launch_once: assert property (cmd_launch_o |=> !cmd_launch_o) else $error("long launch");
    chk_spare_zero: assert property (cmd_launch_o |-> cmd_word_o.spare == 3'h0) else $error("spare set");
    chk_pad_code: assert property (cfg_o.pad_byte == MCHR_PAD_LOW || cfg_o.pad_byte == MCHR_PAD_HIGH)
        else $error("bad pad");
    chk_clock_idle: assert property (!iface_enabled_o [*3] |-> !card_clock_o) else $error("clock runs");
    chk_dto_cause: assert property ($rose(data_timeout_o) |-> $past(data_active_i)) else $error("idle timeout");
endmodule
bind mchr_regs mchr_regs_monitor u_mon (.*);
